// file: hw/port_pin_io_control.sv
`timescale 1ns/1ps
// Operation
// [R1] Every config register writable any time; pin input registers read-only.
// [R2] Written setting may stay inactive; pull is off while driving push-pull.
// [R3] Unimplemented register bits always read back zero.
// [R4] Implemented bits per port as masked in the package tables.
// [R5] Pin input register always returns the real pin level; code returns zero on analog pins with digital input disabled.
// [R6] Data register reads pin level when direction bit selects input.
// [R7] Enabled shared peripheral overrides the general direction bit.
// [R8] Several enabled peripherals: highest ranked slot gets the pin.
// [R9] Output peripherals force output, pull off; SPI drives and pulls itself.
// [R10] Capture, debug, analog and amplifier leave direction to the bit.
// [R11] Input peripherals force input; pull kept; CAN receive kills pulldown.
// [R12] Peripheral override needs the matching routing selection too.
// [R13] Analog pins pass digital input only when their enable is one.
// [R14] Sources: nonmaskable pin, maskable pin, S, P, AD, over-current.
// [R15] Wired-or mode drives only low, high side off.
// [R16] Port request asserts while a flag and its enable are both set.
// [R17] Flags clear on writing one; zero leaves them unchanged.
// [R18] Over-current flag forces the pin low until software clears it.
// [R19] Unowned output pin drives the stored data register bit.
module port_pin_io_control (
  input wire logic CLK_I,
  input wire logic RST_B_I,
  input wire logic CE_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [port_pin_pkg::ADDR_W-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic [port_pin_pkg::NUM_PINS-1:0] PIN_IN_I,
  output logic [port_pin_pkg::NUM_PINS-1:0] PIN_OUT_O,
  output logic [port_pin_pkg::NUM_PINS-1:0] PIN_OE_O,
  output logic [port_pin_pkg::NUM_PINS-1:0] PULL_ENABLE_O,
  output logic [port_pin_pkg::NUM_PINS-1:0] PULL_DOWN_O,
  output logic [port_pin_pkg::NUM_PINS-1:0] REDUCED_DRIVE_O,
  input wire logic [2*port_pin_pkg::NUM_PINS-1:0] PERIPH_EN_I,
  input wire logic [2*port_pin_pkg::NUM_PINS-1:0] ROUTE_SEL_I,
  input wire logic [6*port_pin_pkg::NUM_PINS-1:0] PERIPH_KIND_I,
  input wire logic [2*port_pin_pkg::NUM_PINS-1:0] PERIPH_OUT_I,
  input wire logic [2*port_pin_pkg::NUM_PINS-1:0] PERIPH_OE_I,
  output logic [port_pin_pkg::NUM_PINS-1:0] PERIPH_IN_O,
  input wire logic OVERCURRENT_I,
  input wire logic NONMASKABLE_REQUEST_PIN_B_I,
  input wire logic MASKABLE_REQUEST_PIN_B_I,
  output logic NONMASKABLE_REQ_O,
  output logic MASKABLE_REQ_O,
  output logic PORT_S_INT_O,
  output logic PORT_P_INT_O,
  output logic PORT_AD_INT_O,
  output logic OVERCURRENT_INT_O
);

  localparam int NP = port_pin_pkg::NUM_PORTS;
  localparam int W = port_pin_pkg::PORT_W;

  logic [7:0] data_ff [NP];
  logic [7:0] dir_ff [NP];
  logic [7:0] pull_en_ff [NP];
  logic [7:0] polarity_ff [NP];
  logic [7:0] int_en_ff [NP];
  logic [7:0] int_flag_ff [NP];
  logic [7:0] dig_en_ff [NP];
  logic [7:0] reduced_ff [NP];
  logic [7:0] wired_or_ff [NP];
  logic irq_enable_ff;
  logic [31:0] rdata_ff;
  logic slverr_ff;
  logic oc_meta_ff;
  logic oc_sync_ff;
  logic nmi_meta_ff;
  logic nmi_sync_ff;
  logic irq_meta_ff;
  logic irq_sync_ff;
  logic nmi_req_ff;
  logic irq_req_ff;
  logic port_s_ff;
  logic port_p_ff;
  logic port_ad_ff;
  logic oc_int_ff;

  logic [port_pin_pkg::NUM_PINS-1:0] level_w;
  logic [port_pin_pkg::NUM_PINS-1:0] edge_w;
  logic [2:0] grp;
  logic [3:0] idx;
  logic setup;
  logic wr;
  logic mapped;
  logic [7:0] wbyte;
  logic [7:0] rbyte;
  logic [7:0] sel_level;

  ////////////////////////////////////////////////////////////////////////////
  // APB slave decode

  assign grp = PADDR_I[port_pin_pkg::ADDR_GRP_MSB:port_pin_pkg::ADDR_GRP_LSB];
  assign idx = PADDR_I[port_pin_pkg::ADDR_REG_MSB:port_pin_pkg::ADDR_REG_LSB];
  assign setup = PSEL_I & ~PENABLE_I;
  assign wr = PSEL_I & PENABLE_I & PWRITE_I & ~slverr_ff;
  assign wbyte = PWDATA_I[7:0];

  // Zero wait states: answer is ready in every access phase
  assign PREADY_O = 1'b1;
  assign PRDATA_O = rdata_ff;
  assign PSLVERR_O = slverr_ff;

  // Address map check
  always_comb
  begin
    mapped = 1'b0;
    if (PADDR_I[port_pin_pkg::ADDR_W-1:port_pin_pkg::ADDR_GRP_MSB+1] == '0
        && PADDR_I[port_pin_pkg::ADDR_REG_LSB-1:0] == '0)
    begin
      if (grp == port_pin_pkg::PORT_MISC)
      begin
        mapped = (idx == port_pin_pkg::REG_IRQ_CTRL);
      end
      else if (grp < port_pin_pkg::PORT_MISC)
      begin
        mapped = (idx <= port_pin_pkg::REG_WIRED_OR);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read multiplexer, implemented bits only

  always_comb
  begin
    rbyte = 8'h00;
    sel_level = 8'h00;
    if (grp < port_pin_pkg::PORT_MISC)
    begin
      sel_level = level_w[grp*W +: W];
      case (idx)
        port_pin_pkg::REG_DATA:
          rbyte = (dir_ff[grp] & data_ff[grp])
                  | (~dir_ff[grp] & sel_level); // [R6]
        port_pin_pkg::REG_INPUT:
          rbyte = sel_level; // [R5]
        port_pin_pkg::REG_DIR:
          rbyte = dir_ff[grp];
        port_pin_pkg::REG_PULL_EN:
          rbyte = pull_en_ff[grp];
        port_pin_pkg::REG_POLARITY:
          rbyte = polarity_ff[grp];
        port_pin_pkg::REG_INT_EN:
          rbyte = int_en_ff[grp];
        port_pin_pkg::REG_INT_FLAG:
          rbyte = int_flag_ff[grp];
        port_pin_pkg::REG_DIG_EN:
          rbyte = dig_en_ff[grp];
        port_pin_pkg::REG_REDUCED:
          rbyte = reduced_ff[grp];
        port_pin_pkg::REG_WIRED_OR:
          rbyte = wired_or_ff[grp];
        default:
          rbyte = 8'h00;
      endcase
      rbyte = rbyte & port_pin_pkg::PIN_MASK[grp]
              | (idx == port_pin_pkg::REG_INT_EN
                 || idx == port_pin_pkg::REG_INT_FLAG
                 ? rbyte & port_pin_pkg::INT_REG_MASK[grp] : 8'h00); // [R3]
    end
    else if (grp == port_pin_pkg::PORT_MISC)
    begin
      rbyte[port_pin_pkg::IRQ_EN_BIT] = irq_enable_ff;
    end
  end

  // Read data and error set at setup
  always_ff @(posedge CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      rdata_ff <= 32'h0000_0000;
      slverr_ff <= 1'b0;
    end
    else if (CE_I && setup)
    begin
      rdata_ff <= {24'h00_0000, (PWRITE_I || !mapped) ? 8'h00 : rbyte};
      slverr_ff <= ~mapped;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers, masked on write

  always_ff @(posedge CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      for (int p = 0; p < NP; p++)
      begin
        data_ff[p] <= port_pin_pkg::RESET_BYTE;
        dir_ff[p] <= port_pin_pkg::RESET_BYTE;
        pull_en_ff[p] <= port_pin_pkg::RESET_BYTE;
        polarity_ff[p] <= port_pin_pkg::RESET_BYTE;
        int_en_ff[p] <= port_pin_pkg::RESET_BYTE;
        dig_en_ff[p] <= port_pin_pkg::RESET_BYTE;
        reduced_ff[p] <= port_pin_pkg::RESET_BYTE;
        wired_or_ff[p] <= port_pin_pkg::RESET_BYTE;
      end
    end
    else if (CE_I && wr && grp < port_pin_pkg::PORT_MISC)
    begin
      // Input register has no storage
      case (idx) // [R1]
        port_pin_pkg::REG_DATA:
          data_ff[grp] <= wbyte & port_pin_pkg::PIN_MASK[grp]; // [R4]
        port_pin_pkg::REG_DIR:
          dir_ff[grp] <= wbyte & port_pin_pkg::PIN_MASK[grp]; // [R4]
        port_pin_pkg::REG_PULL_EN:
          pull_en_ff[grp] <= wbyte & port_pin_pkg::PIN_MASK[grp];
        port_pin_pkg::REG_POLARITY:
          polarity_ff[grp] <= wbyte & port_pin_pkg::PIN_MASK[grp];
        port_pin_pkg::REG_INT_EN:
          int_en_ff[grp] <= wbyte & port_pin_pkg::INT_REG_MASK[grp]; // [R4]
        port_pin_pkg::REG_DIG_EN:
          dig_en_ff[grp] <= wbyte & port_pin_pkg::DIG_EN_MASK[grp]; // [R4]
        port_pin_pkg::REG_REDUCED:
          reduced_ff[grp] <= wbyte & port_pin_pkg::REDUCED_MASK[grp]; // [R4]
        port_pin_pkg::REG_WIRED_OR:
          wired_or_ff[grp] <= wbyte & port_pin_pkg::WIRED_OR_MASK[grp];
        default:
        begin
        end
      endcase
    end
  end

  // Maskable request enable, off out of reset
  always_ff @(posedge CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      irq_enable_ff <= 1'b0;
    end
    else if (CE_I && wr && grp == port_pin_pkg::PORT_MISC)
    begin
      irq_enable_ff <= wbyte[port_pin_pkg::IRQ_EN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt flags: hardware set beats a same-cycle clear

  always_ff @(posedge CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      for (int p = 0; p < NP; p++)
      begin
        int_flag_ff[p] <= port_pin_pkg::RESET_BYTE;
      end
    end
    else if (CE_I)
    begin
      for (int p = 0; p < NP; p++)
      begin
        logic [7:0] clr;
        logic [7:0] set;
        clr = (wr && grp == 3'(p) && idx == port_pin_pkg::REG_INT_FLAG)
              ? wbyte : 8'h00; // [R17]
        set = edge_w[p*W +: W] & port_pin_pkg::INT_MASK[p];
        if (p == int'(port_pin_pkg::PORT_P))
        begin
          set[port_pin_pkg::OC_BIT] = oc_sync_ff;
        end
        int_flag_ff[p] <= ((int_flag_ff[p] & ~clr) | set)
                          & port_pin_pkg::INT_REG_MASK[p]; // [R17]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request and over-current pins, two-flop syncs

  always_ff @(posedge CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      oc_meta_ff <= 1'b0;
      oc_sync_ff <= 1'b0;
      nmi_meta_ff <= 1'b1;
      nmi_sync_ff <= 1'b1;
      irq_meta_ff <= 1'b1;
      irq_sync_ff <= 1'b1;
    end
    else if (CE_I)
    begin
      oc_meta_ff <= OVERCURRENT_I;
      oc_sync_ff <= oc_meta_ff;
      nmi_meta_ff <= NONMASKABLE_REQUEST_PIN_B_I;
      nmi_sync_ff <= nmi_meta_ff;
      irq_meta_ff <= MASKABLE_REQUEST_PIN_B_I;
      irq_sync_ff <= irq_meta_ff;
    end
  end

  // Registered request outputs
  always_ff @(posedge CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      nmi_req_ff <= 1'b0;
      irq_req_ff <= 1'b0;
      port_s_ff <= 1'b0;
      port_p_ff <= 1'b0;
      port_ad_ff <= 1'b0;
      oc_int_ff <= 1'b0;
    end
    else if (CE_I)
    begin
      nmi_req_ff <= ~nmi_sync_ff; // [R14]
      irq_req_ff <= ~irq_sync_ff & irq_enable_ff; // [R14]
      port_s_ff <= |(int_flag_ff[port_pin_pkg::PORT_S]
                     & int_en_ff[port_pin_pkg::PORT_S]
                     & port_pin_pkg::INT_MASK[port_pin_pkg::PORT_S]); // [R16]
      port_p_ff <= |(int_flag_ff[port_pin_pkg::PORT_P]
                     & int_en_ff[port_pin_pkg::PORT_P]
                     & port_pin_pkg::INT_MASK[port_pin_pkg::PORT_P]); // [R16]
      port_ad_ff <= |(int_flag_ff[port_pin_pkg::PORT_ADL]
                      & int_en_ff[port_pin_pkg::PORT_ADL])
                    | |(int_flag_ff[port_pin_pkg::PORT_ADH]
                        & int_en_ff[port_pin_pkg::PORT_ADH]); // [R16]
      oc_int_ff <= int_flag_ff[port_pin_pkg::PORT_P][port_pin_pkg::OC_BIT]
                   & int_en_ff[port_pin_pkg::PORT_P][port_pin_pkg::OC_BIT];
    end
  end

  assign NONMASKABLE_REQ_O = nmi_req_ff;
  assign MASKABLE_REQ_O = irq_req_ff;
  assign PORT_S_INT_O = port_s_ff;
  assign PORT_P_INT_O = port_p_ff;
  assign PORT_AD_INT_O = port_ad_ff;
  assign OVERCURRENT_INT_O = oc_int_ff; // [R14]
  assign PERIPH_IN_O = level_w;

  ////////////////////////////////////////////////////////////////////////////
  // Pin cells; absent positions idle

  for (genvar p = 0; p < NP; p++)
  begin : g_port
    for (genvar b = 0; b < W; b++)
    begin : g_bit
      localparam int N = p * W + b;
      if (port_pin_pkg::PIN_MASK[p][b])
      begin : g_cell
        logic digital_input_enable;
        logic force_low;
        // Non-analog pins always pass input
        assign digital_input_enable = port_pin_pkg::DIG_EN_MASK[p][b]
                     ? dig_en_ff[p][b] : 1'b1; // [R13]
        assign force_low = (p == int'(port_pin_pkg::PORT_P)
                            && b == port_pin_pkg::OC_PIN_BIT)
                           ? int_flag_ff[p][port_pin_pkg::OC_BIT]
                           : 1'b0; // [R18]
        pin_cell u_cell (
          .clk_i(CLK_I),
          .rst_b_i(RST_B_I),
          .ce_i(CE_I),
          .pin_i(PIN_IN_I[N]),
          .gpio_out_i(data_ff[p][b]),
          .gpio_dir_i(dir_ff[p][b]),
          .pull_en_i(pull_en_ff[p][b]),
          .pull_pol_i(polarity_ff[p][b]),
          .wom_i(wired_or_ff[p][b]),
          .rdr_i(reduced_ff[p][b]),
          .die_i(digital_input_enable),
          .force_low_i(force_low),
          .slot_en_i(PERIPH_EN_I[2*N +: 2] & ROUTE_SEL_I[2*N +: 2]), // [R12]
          .slot_out_i(PERIPH_OUT_I[2*N +: 2]),
          .slot_oe_i(PERIPH_OE_I[2*N +: 2]),
          .kind0_i(port_pin_pkg::periph_kind_type'(PERIPH_KIND_I[6*N +: 3])),
          .kind1_i(port_pin_pkg::periph_kind_type'(
                     PERIPH_KIND_I[6*N+3 +: 3])),
          .pin_out_o(PIN_OUT_O[N]),
          .pin_oe_o(PIN_OE_O[N]),
          .pull_on_o(PULL_ENABLE_O[N]),
          .pull_down_o(PULL_DOWN_O[N]),
          .reduced_o(REDUCED_DRIVE_O[N]),
          .level_o(level_w[N]),
          .edge_o(edge_w[N])
        );
      end
      else
      begin : g_none
        assign PIN_OUT_O[N] = 1'b0;
        assign PIN_OE_O[N] = 1'b0;
        assign PULL_ENABLE_O[N] = 1'b0;
        assign PULL_DOWN_O[N] = 1'b0;
        assign REDUCED_DRIVE_O[N] = 1'b0;
        assign level_w[N] = 1'b0;
        assign edge_w[N] = 1'b0;
      end
    end
  end

endmodule

// file: hw/port_pin_pkg.sv
package port_pin_pkg;

  // Geometry of the port block
  localparam int NUM_PORTS = 6;
  localparam int PORT_W = 8;
  localparam int NUM_PINS = NUM_PORTS * PORT_W;
  localparam int SLOTS = 2;
  localparam int KIND_W = 3;

  // Port indices, one register group each
  localparam logic [2:0] PORT_E = 3'h0;
  localparam logic [2:0] PORT_ADH = 3'h1;
  localparam logic [2:0] PORT_ADL = 3'h2;
  localparam logic [2:0] PORT_T = 3'h3;
  localparam logic [2:0] PORT_S = 3'h4;
  localparam logic [2:0] PORT_P = 3'h5;
  localparam logic [2:0] PORT_MISC = 3'h6;

  // Register index inside a group
  localparam logic [3:0] REG_DATA = 4'h0;
  localparam logic [3:0] REG_INPUT = 4'h1;
  localparam logic [3:0] REG_DIR = 4'h2;
  localparam logic [3:0] REG_PULL_EN = 4'h3;
  localparam logic [3:0] REG_POLARITY = 4'h4;
  localparam logic [3:0] REG_INT_EN = 4'h5;
  localparam logic [3:0] REG_INT_FLAG = 4'h6;
  localparam logic [3:0] REG_DIG_EN = 4'h7;
  localparam logic [3:0] REG_REDUCED = 4'h8;
  localparam logic [3:0] REG_WIRED_OR = 4'h9;
  localparam logic [3:0] REG_IRQ_CTRL = 4'h0;

  // Byte address = group * 0x40 + index * 4
  localparam int ADDR_W = 12;
  localparam int ADDR_GRP_LSB = 6;
  localparam int ADDR_REG_LSB = 2;
  localparam int ADDR_GRP_MSB = 8;
  localparam int ADDR_REG_MSB = 5;

  // Field positions
  localparam int IRQ_EN_BIT = 0;
  localparam int OC_BIT = 7;
  localparam int OC_PIN_BIT = 0;

  localparam logic [7:0] RESET_BYTE = 8'h00;

  // Implemented bits per port, E ADH ADL T S P
  localparam logic [7:0] PIN_MASK [NUM_PORTS] =
    '{8'h03, 8'h01, 8'hFF, 8'h0F, 8'h3F, 8'h07};
  localparam logic [7:0] INT_MASK [NUM_PORTS] =
    '{8'h00, 8'h01, 8'hFF, 8'h00, 8'h3F, 8'h07};
  localparam logic [7:0] INT_REG_MASK [NUM_PORTS] =
    '{8'h00, 8'h01, 8'hFF, 8'h00, 8'h3F, 8'h87};
  localparam logic [7:0] DIG_EN_MASK [NUM_PORTS] =
    '{8'h00, 8'h01, 8'hFF, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] REDUCED_MASK [NUM_PORTS] =
    '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
  localparam logic [7:0] WIRED_OR_MASK [NUM_PORTS] =
    '{8'h00, 8'h00, 8'h00, 8'h00, 8'h3F, 8'h00};

  // What an enabled peripheral does to a pin
  typedef enum logic [KIND_W-1:0] {
    KIND_KEEP,
    KIND_OUT,
    KIND_IN,
    KIND_SPI,
    KIND_CAN_RX
  } periph_kind_type;

endpackage

// file: hw/pin_cell.sv
`timescale 1ns/1ps
module pin_cell (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic pin_i,
  input wire logic gpio_out_i,
  input wire logic gpio_dir_i,
  input wire logic pull_en_i,
  input wire logic pull_pol_i,
  input wire logic wom_i,
  input wire logic rdr_i,
  input wire logic die_i,
  input wire logic force_low_i,
  input wire logic [1:0] slot_en_i,
  input wire logic [1:0] slot_out_i,
  input wire logic [1:0] slot_oe_i,
  input wire port_pin_pkg::periph_kind_type kind0_i,
  input wire port_pin_pkg::periph_kind_type kind1_i,
  output logic pin_out_o,
  output logic pin_oe_o,
  output logic pull_on_o,
  output logic pull_down_o,
  output logic reduced_o,
  output logic level_o,
  output logic edge_o
);

  logic meta_ff;
  logic sync_ff;
  logic prev_ff;
  logic nxt_out;
  logic nxt_oe;
  logic nxt_pull;
  logic own;
  logic own_out;
  logic own_oe;
  port_pin_pkg::periph_kind_type own_kind;

  // Pin level through two flops
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      prev_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      meta_ff <= pin_i;
      sync_ff <= meta_ff;
      prev_ff <= level_o;
    end
  end

  // Analog pins feed digital logic only when enabled
  assign level_o = sync_ff & die_i; // [R13] [R5]
  // Active edge follows polarity: one is rising, zero falling
  assign edge_o = pull_pol_i ? (level_o & ~prev_ff) : (~level_o & prev_ff);

  // Slot zero ranks above slot one
  assign own = |slot_en_i; // [R8]
  assign own_kind = slot_en_i[0] ? kind0_i : kind1_i; // [R8]
  assign own_out = slot_en_i[0] ? slot_out_i[0] : slot_out_i[1];
  assign own_oe = slot_en_i[0] ? slot_oe_i[0] : slot_oe_i[1];

  // Direction, value and pull resolution
  always_comb
  begin
    nxt_out = gpio_out_i; // [R19]
    nxt_oe = gpio_dir_i; // [R19] [R10]
    nxt_pull = pull_en_i;
    if (own)
    begin
      case (own_kind) // [R7]
        port_pin_pkg::KIND_OUT:
        begin
          nxt_out = own_out; // [R9]
          nxt_oe = 1'b1; // [R9]
          nxt_pull = 1'b0; // [R9]
        end
        port_pin_pkg::KIND_SPI:
        begin
          nxt_out = own_out;
          nxt_oe = own_oe; // [R9]
          nxt_pull = pull_en_i & ~own_oe; // [R9]
        end
        port_pin_pkg::KIND_IN:
        begin
          nxt_oe = 1'b0; // [R11]
        end
        port_pin_pkg::KIND_CAN_RX:
        begin
          nxt_oe = 1'b0; // [R11]
          nxt_pull = pull_en_i & ~pull_pol_i; // [R11]
        end
        default:
        begin
          nxt_oe = gpio_dir_i; // [R10]
        end
      endcase
    end
    // Open drain: never drive the high level
    if (wom_i && nxt_out)
    begin
      nxt_oe = 1'b0; // [R15]
    end
    // Over-current wins over every owner
    if (force_low_i)
    begin
      nxt_out = 1'b0; // [R18]
      nxt_oe = 1'b1; // [R18]
    end
    // Pull stays off while driving push-pull
    if (nxt_oe && !wom_i)
    begin
      nxt_pull = 1'b0; // [R2]
    end
  end

  // Registered pad controls
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pin_out_o <= 1'b0;
      pin_oe_o <= 1'b0;
      pull_on_o <= 1'b0;
      pull_down_o <= 1'b0;
      reduced_o <= 1'b0;
    end
    else if (ce_i)
    begin
      pin_out_o <= nxt_out;
      pin_oe_o <= nxt_oe;
      pull_on_o <= nxt_pull;
      pull_down_o <= pull_pol_i;
      reduced_o <= rdr_i & nxt_oe;
    end
  end

endmodule

// file: testbench/port_pin_io_control_asserts.sv
`timescale 1ns/1ps
module port_pin_io_control_chk (
  input logic CLK_I,
  input logic RST_B_I,
  input logic PSEL_I,
  input logic PENABLE_I,
  input logic [11:0] PADDR_I,
  input logic [31:0] PRDATA_O,
  input logic PSLVERR_O,
  input logic [47:0] PIN_IN_I,
  input logic [47:0] PIN_OUT_O,
  input logic [47:0] PIN_OE_O,
  input logic [47:0] PULL_ENABLE_O,
  input logic [47:0] REDUCED_DRIVE_O,
  input logic [47:0] PERIPH_IN_O,
  input logic OVERCURRENT_I,
  input logic NONMASKABLE_REQUEST_PIN_B_I,
  input logic MASKABLE_REQUEST_PIN_B_I,
  input logic NONMASKABLE_REQ_O,
  input logic MASKABLE_REQ_O
);
  // S and P0 skip the pull test
  localparam logic [47:0] impl = 48'h073F_0FFF_0103;
  localparam logic [47:0] nopull = 48'hFE00_FFFF_FFFF;
  localparam logic [47:0] p0 = 48'h0100_0000_0000;

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_B_I);

  // Bus side
  a_rsvd_reads_zero: assert property (
    PSEL_I && !PENABLE_I && PADDR_I >= 12'h1C0
    |=> PSLVERR_O && PRDATA_O == 32'h0000_0000)
    else $error("rsvd read");
  a_upper_bits_zero: assert property (
    PRDATA_O[31:8] == 24'h00_0000) else $error("upper bits");
  // Pad side
  a_pull_off_driven: assert property (
    (PIN_OE_O & PULL_ENABLE_O & nopull) == '0)
    else $error("pull driven");
  a_unimpl_pins_quiet: assert property (
    ((PIN_OE_O | PIN_OUT_O | PULL_ENABLE_O) & ~impl) == '0)
    else $error("absent pin");
  a_reduced_p0_only: assert property (
    (REDUCED_DRIVE_O & ~p0) == '0)
    else $error("reduced off P0");
  a_pin_level_path: assert property (
    $stable(PIN_IN_I[0]) [*3] |-> PERIPH_IN_O[0] == PIN_IN_I[0])
    else $error("pin level");
  // Request pins 3 edges late, over-current pin 4
  a_nmi_follows_pin: assert property (
    !NONMASKABLE_REQUEST_PIN_B_I [*4] |-> NONMASKABLE_REQ_O)
    else $error("nmi missing");
  a_nmi_idle: assert property (
    NONMASKABLE_REQUEST_PIN_B_I [*4] |-> !NONMASKABLE_REQ_O)
    else $error("nmi stuck");
  a_irq_idle: assert property (
    MASKABLE_REQUEST_PIN_B_I [*4] |-> !MASKABLE_REQ_O)
    else $error("irq stuck");
  a_overcurrent_low: assert property (
    OVERCURRENT_I [*5] |-> PIN_OE_O[40] && !PIN_OUT_O[40])
    else $error("oc pin high");
endmodule

bind port_pin_io_control port_pin_io_control_chk i_chk (.*);

// file: testbench/port_pin_io_control_tb_top.sv
`timescale 1ns/1ps
module port_pin_io_control_tb_top;
  logic CLK_I = 1'b0;
  logic RST_B_I = 1'b0;
  logic CE_I = 1'b1;
  logic PSEL_I = 1'b0, PENABLE_I = 1'b0, PWRITE_I = 1'b0;
  logic [11:0] PADDR_I = '0;
  logic [31:0] PWDATA_I = '0, PRDATA_O, rd;
  logic PREADY_O, PSLVERR_O, OVERCURRENT_I = 1'b0;
  logic [47:0] PIN_IN_I = '0, PIN_OUT_O, PIN_OE_O, PULL_ENABLE_O;
  logic [47:0] PULL_DOWN_O, REDUCED_DRIVE_O, PERIPH_IN_O;
  logic [95:0] PERIPH_EN_I = '0, ROUTE_SEL_I = '0;
  logic [95:0] PERIPH_OUT_I = '0, PERIPH_OE_I = '0;
  logic [287:0] PERIPH_KIND_I = '0;
  logic NONMASKABLE_REQUEST_PIN_B_I = 1'b1, MASKABLE_REQUEST_PIN_B_I = 1'b1;
  logic NONMASKABLE_REQ_O, MASKABLE_REQ_O, PORT_S_INT_O, PORT_P_INT_O;
  logic PORT_AD_INT_O, OVERCURRENT_INT_O;
  int n_mismatch = 0;
  int comparisons = 0;

  port_pin_io_control i_dut (.*);

  // Bench clock, 8 ns period
  always #4 CLK_I = ~CLK_I;

  ////////////////////////////////////////
  // Compare, report at once
  task automatic check(input string what, input logic [47:0] seen,
                       input logic [47:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge CLK_I);
  endtask

  // APB transfer, waits for pready
  task automatic apb(input logic wr, input int g, input int r,
                     input logic [7:0] d);
    int n;
    @(posedge CLK_I);
    PSEL_I <= 1'b1;
    PENABLE_I <= 1'b0;
    PWRITE_I <= wr;
    PADDR_I <= 12'(g * 64 + r * 4);
    PWDATA_I <= 32'(d);
    @(posedge CLK_I);
    PENABLE_I <= 1'b1;
    n = 0;
    do
    begin
      @(posedge CLK_I);
      n++;
    end
    while (PREADY_O !== 1'b1 && n < 20);
    rd = PRDATA_O;
    PSEL_I <= 1'b0;
    PENABLE_I <= 1'b0;
  endtask

  task automatic rchk(input string what, input int g, input int r,
                      input logic [7:0] exp);
    apb(1'b0, g, r, 8'h00);
    check(what, rd, exp);
  endtask

  function automatic logic [7:0] mask_of(input int g, input int r);
    case (r)
      5: return port_pin_pkg::INT_REG_MASK[g];
      7: return port_pin_pkg::DIG_EN_MASK[g];
      8: return port_pin_pkg::REDUCED_MASK[g];
      9: return port_pin_pkg::WIRED_OR_MASK[g];
      default: return port_pin_pkg::PIN_MASK[g];
    endcase
  endfunction

  ////////////////////////////////////////
  // All ones in each port register but the flags; dir first so data reads back
  task automatic t_regs();
    for (int g = 0; g < 6; g++)
    begin
      for (int r = 9; r >= 0; r--)
      begin
        if (r != 1 && r != 6)
        begin
          apb(1'b1, g, r, 8'hFF);
          rchk("reg", g, r, mask_of(g, r));
        end
      end
      apb(1'b1, g, 1, 8'hFF);
      rchk("pin input", g, 1, 8'h00);
    end
    rchk("unmapped", 7, 0, 8'h00);
    cyc(3);
    check("oe wired", PIN_OE_O, 48'h0700_0FFF_0103);
    check("out", PIN_OUT_O & 48'hFF00_FFFF_FFFF, 48'h0700_0FFF_0103);
    check("pull", PULL_ENABLE_O, 48'h003F_0000_0000);
    check("pull down", PULL_DOWN_O, 48'h073F_0FFF_0103);
    check("reduced", REDUCED_DRIVE_O, 48'h0100_0000_0000);
    apb(1'b1, 4, 9, 8'h00);
    cyc(3);
    check("oe push", PIN_OE_O, 48'h073F_0FFF_0103);
    check("pull push", PULL_ENABLE_O, 48'h0000_0000_0000);
  endtask

  // Pins as inputs, rising edges
  task automatic t_input();
    for (int g = 0; g < 6; g++)
      apb(1'b1, g, 2, 8'h00);
    PIN_IN_I <= 48'h0201_00A5_0000;
    cyc(5);
    rchk("input reg", 2, 1, 8'hA5);
    rchk("data as input", 2, 0, 8'hA5);
    check("periph in", PERIPH_IN_O, 48'h0201_00A5_0000);
    check("ad int", PORT_AD_INT_O, 1'b1);
    check("s p int", {PORT_S_INT_O, PORT_P_INT_O}, 2'b11);
    rchk("flag", 2, 6, 8'hA5);
    apb(1'b1, 2, 6, 8'h05);
    rchk("flag w1c", 2, 6, 8'hA0);
    apb(1'b1, 2, 6, 8'h00);
    rchk("flag w0", 2, 6, 8'hA0);
    apb(1'b1, 2, 6, 8'hA0);
    cyc(2);
    check("ad int off", PORT_AD_INT_O, 1'b0);
    apb(1'b1, 2, 7, 8'h00);
    cyc(3);
    check("digital off", PERIPH_IN_O, 48'h0201_0000_0000);
  endtask

  // Peripheral ownership of pin T0 (bit 24)
  task automatic t_periph();
    PERIPH_EN_I[48] <= 1'b1;
    PERIPH_KIND_I[146:144] <= port_pin_pkg::KIND_OUT;
    PERIPH_OUT_I[48] <= 1'b1;
    cyc(3);
    check("no route", PIN_OE_O[24], 1'b0);
    ROUTE_SEL_I[48] <= 1'b1;
    cyc(3);
    check("forced out", {PIN_OE_O[24], PIN_OUT_O[24], PULL_ENABLE_O[24]},
          3'b110);
    PERIPH_EN_I[49] <= 1'b1;
    ROUTE_SEL_I[49] <= 1'b1;
    PERIPH_KIND_I[149:147] <= port_pin_pkg::KIND_IN;
    cyc(3);
    check("slot0 wins", PIN_OE_O[24], 1'b1);
    PERIPH_EN_I[48] <= 1'b0;
    cyc(3);
    check("forced in", {PIN_OE_O[24], PULL_ENABLE_O[24]}, 2'b01);
    PERIPH_KIND_I[149:147] <= port_pin_pkg::KIND_CAN_RX;
    cyc(3);
    check("can pulldown", PULL_ENABLE_O[24], 1'b0);
    PERIPH_KIND_I[149:147] <= port_pin_pkg::KIND_KEEP;
    cyc(3);
    check("keep in", PIN_OE_O[24], 1'b0);
    apb(1'b1, 3, 2, 8'h01);
    cyc(3);
    check("keep out", PIN_OE_O[24], 1'b1);
  endtask

  // Request pins, maskable one gated
  task automatic t_req();
    NONMASKABLE_REQUEST_PIN_B_I <= 1'b0;
    MASKABLE_REQUEST_PIN_B_I <= 1'b0;
    cyc(5);
    check("nmi", NONMASKABLE_REQ_O, 1'b1);
    check("irq masked", MASKABLE_REQ_O, 1'b0);
    apb(1'b1, 6, 0, 8'h01);
    cyc(3);
    check("irq", MASKABLE_REQ_O, 1'b1);
    NONMASKABLE_REQUEST_PIN_B_I <= 1'b1;
    MASKABLE_REQUEST_PIN_B_I <= 1'b1;
    cyc(5);
    check("req idle", {NONMASKABLE_REQ_O, MASKABLE_REQ_O}, 2'b00);
  endtask

  // Trip on P0 holds it low until cleared
  task automatic t_oc();
    apb(1'b1, 5, 0, 8'h01);
    apb(1'b1, 5, 2, 8'h01);
    cyc(3);
    check("p0 high", PIN_OUT_O[40], 1'b1);
    OVERCURRENT_I <= 1'b1;
    cyc(6);
    OVERCURRENT_I <= 1'b0;
    check("oc int", OVERCURRENT_INT_O, 1'b1);
    cyc(5);
    check("oc held", {PIN_OE_O[40], PIN_OUT_O[40]}, 2'b10);
    apb(1'b1, 5, 6, 8'h80);
    cyc(3);
    check("oc clear", {PIN_OUT_O[40], OVERCURRENT_INT_O}, 2'b10);
  endtask

  ////////////////////////////////////////
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (6) @(posedge CLK_I);
    RST_B_I <= 1'b1;
    t_regs();
    t_input();
    t_periph();
    t_req();
    t_oc();
    close_out();
  end

  // Watchdog, far past the run's length
  initial
  begin
    repeat (20000) @(posedge CLK_I);
    n_mismatch++;
    close_out();
  end
endmodule
